// File: verilog/vsl_pkg.sv
// package of the sync and luma control register bank
// assumes a subaddress port from the serial control bus core on the same clock
// How it works
// - auto detect on follows detector, else selection
// - selection bit forces 50 or 60 Hz
// - odd/even toggles interlaced only, unless forced
// - time constant codes TV, VTR, fast
// - loop bit opens PLL, frequency held
// - noise codes normal, fast, free, bypass
// - bypass bit disables trap and comb
// - comb select chooses comb over trap
// - delay bit adds one or two lines, none with comb
// - bandwidth bit picks narrow or wide notch
// - sharpness codes flat, peaking, low-pass
// - brightness is unsigned offset, 128 nominal
package vsl_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] SYNC_CONTROL_ADDR = 8'h08;
  localparam logic [7:0] LUMINANCE_CONTROL_ADDR = 8'h09;
  localparam logic [7:0] LUMA_BRIGHTNESS_OFFSET_ADDR = 8'h0A;
  localparam logic [7:0] SYNC_CONTROL_RESET = 8'h98;
  localparam logic [7:0] LUMINANCE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] LUMA_BRIGHTNESS_OFFSET_RESET = 8'h80;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ==========================================================
  // field positions
  localparam int AUTO_FIELD_DETECT_BIT = 7;
  localparam int FIELD_RATE_SELECT_BIT = 6;
  localparam int FORCED_FIELD_TOGGLE_BIT = 5;
  localparam int HORIZ_TIME_CONSTANT_LSB = 3;
  localparam int HORIZ_LOOP_OPEN_BIT = 2;
  localparam int VERT_NOISE_MODE_LSB = 0;
  localparam int TRAP_COMB_BYPASS_BIT = 7;
  localparam int COMB_SELECT_BIT = 6;
  localparam int EXTRA_LINE_DELAY_BIT = 5;
  localparam int NOTCH_BANDWIDTH_SELECT_BIT = 4;
  localparam int SHARPNESS_SELECT_LSB = 0;
  // ==========================================================
  // codes
  localparam logic [1:0] HTC_TV = 2'h0;
  localparam logic [1:0] HTC_VTR = 2'h1;
  localparam logic [1:0] HTC_FAST = 2'h3;
  localparam logic [1:0] DELAY_LINES_NTSC = 2'h1;
  localparam logic [1:0] DELAY_LINES_PAL = 2'h2;
  localparam logic [8:0] BRIGHTNESS_NOMINAL = 9'h080;
  localparam logic [3:0] PEAK_BASE = 4'h8;
  // ==========================================================
  // decoded controls
  typedef struct packed {
    logic field60; // 1: 60 Hz 525 lines, 0: 50 Hz 625 lines
    logic hmodeTv;
    logic hmodeVtr;
    logic hmodeFast;
    logic horizLoopOpen;
    logic vnrNormal;
    logic vnrFast;
    logic vnrFreeRun;
    logic vnrBypass;
  } vsl_sync_ctl_s;
  typedef struct packed {
    logic trapOn;
    logic combOn;
    logic [1:0] extraLines;
    logic notchWide;
    logic sharpFlat;
    logic peakOn;
    logic [2:0] peakStrength;
    logic lowpassOn;
    logic [2:0] lowpassStrength;
  } vsl_luma_ctl_s;
endpackage

// File: verilog/vsl_regs.sv
// sync and luma control register bank with decoded controls
// assumes subaddress strobes from a bus core and video strobes on clk
`timescale 1ns/1ps
module vsl_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // subaddress port
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] subAddr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  // video status
  input wire logic detected60,
  input wire logic sourceInterlaced,
  input wire logic fieldStart,
  input wire logic [7:0] lumaIn,
  // decoded controls
  output vsl_pkg::vsl_sync_ctl_s syncCtl,
  output vsl_pkg::vsl_luma_ctl_s lumaCtl,
  output logic oddEven,
  output logic [7:0] lumaOut
);
  // ==========================================================
  // registers
  logic [7:0] syncControl_reg;
  logic [7:0] luminanceControl_reg;
  logic [7:0] lumaBrightnessOffset_reg;
  logic [9:0] lumaSum;
  logic [3:0] sharp;
  logic [1:0] htc;
  logic [1:0] vnr;
  logic combPath;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncControl_reg <= vsl_pkg::SYNC_CONTROL_RESET;
      luminanceControl_reg <= vsl_pkg::LUMINANCE_CONTROL_RESET;
      lumaBrightnessOffset_reg <= vsl_pkg::LUMA_BRIGHTNESS_OFFSET_RESET;
    end else if (wrEn) begin
      if (subAddr == vsl_pkg::SYNC_CONTROL_ADDR)
        syncControl_reg <= wrData;
      if (subAddr == vsl_pkg::LUMINANCE_CONTROL_ADDR)
        luminanceControl_reg <= wrData;
      if (subAddr == vsl_pkg::LUMA_BRIGHTNESS_OFFSET_ADDR)
        lumaBrightnessOffset_reg <= wrData;
    end
  end

  // read port, one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= 8'h00;
    end else if (rdEn) begin
      unique case (subAddr)
        vsl_pkg::SYNC_CONTROL_ADDR: rdData <= syncControl_reg;
        vsl_pkg::LUMINANCE_CONTROL_ADDR: rdData <= luminanceControl_reg;
        vsl_pkg::LUMA_BRIGHTNESS_OFFSET_ADDR:
          rdData <= lumaBrightnessOffset_reg;
        default: rdData <= vsl_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ==========================================================
  // sync decode
  assign htc = syncControl_reg[vsl_pkg::HORIZ_TIME_CONSTANT_LSB +: 2];
  assign vnr = syncControl_reg[vsl_pkg::VERT_NOISE_MODE_LSB +: 2];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncCtl <= '0;
    end else begin
      syncCtl.field60 <= syncControl_reg[vsl_pkg::AUTO_FIELD_DETECT_BIT] ?
        detected60 : syncControl_reg[vsl_pkg::FIELD_RATE_SELECT_BIT];
      // time constant, reserved code runs as fast
      syncCtl.hmodeTv <= (htc == vsl_pkg::HTC_TV);
      syncCtl.hmodeVtr <= (htc == vsl_pkg::HTC_VTR);
      syncCtl.hmodeFast <= htc[1];
      syncCtl.horizLoopOpen <= syncControl_reg[vsl_pkg::HORIZ_LOOP_OPEN_BIT];
      syncCtl.vnrNormal <= (vnr == 2'h0);
      syncCtl.vnrFast <= (vnr == 2'h1);
      syncCtl.vnrFreeRun <= (vnr == 2'h2);
      syncCtl.vnrBypass <= (vnr == 2'h3);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oddEven <= 1'b0;
    end else if (fieldStart && (sourceInterlaced ||
        syncControl_reg[vsl_pkg::FORCED_FIELD_TOGGLE_BIT])) begin
      oddEven <= ~oddEven;
    end
  end

  // ==========================================================
  // luma decode
  assign sharp = luminanceControl_reg[vsl_pkg::SHARPNESS_SELECT_LSB +: 4];
  assign combPath = !luminanceControl_reg[vsl_pkg::TRAP_COMB_BYPASS_BIT] &&
    luminanceControl_reg[vsl_pkg::COMB_SELECT_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lumaCtl <= '0;
    end else begin
      lumaCtl.trapOn <= !luminanceControl_reg[vsl_pkg::TRAP_COMB_BYPASS_BIT]
        && !luminanceControl_reg[vsl_pkg::COMB_SELECT_BIT];
      lumaCtl.combOn <= combPath;
      if (luminanceControl_reg[vsl_pkg::EXTRA_LINE_DELAY_BIT] && !combPath)
        lumaCtl.extraLines <= syncCtl.field60 ? vsl_pkg::DELAY_LINES_NTSC :
          vsl_pkg::DELAY_LINES_PAL;
      else
        lumaCtl.extraLines <= 2'h0;
      lumaCtl.notchWide <=
        luminanceControl_reg[vsl_pkg::NOTCH_BANDWIDTH_SELECT_BIT];
      lumaCtl.sharpFlat <= (sharp == 4'h0);
      lumaCtl.peakOn <= !sharp[3] && (sharp != 4'h0);
      lumaCtl.peakStrength <= sharp[3] || sharp == 4'h0 ? 3'h0 :
        3'(vsl_pkg::PEAK_BASE - sharp);
      lumaCtl.lowpassOn <= sharp[3];
      lumaCtl.lowpassStrength <= sharp[3] ? sharp[2:0] : 3'h0;
    end
  end

  assign lumaSum = {2'b00, lumaIn} + {2'b00, lumaBrightnessOffset_reg} -
    {1'b0, vsl_pkg::BRIGHTNESS_NOMINAL};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lumaOut <= 8'h00;
    end else if (lumaSum[9]) begin
      lumaOut <= 8'h00;
    end else if (lumaSum[8]) begin
      lumaOut <= 8'hFF;
    end else begin
      lumaOut <= lumaSum[7:0];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_FIELD_AUTO: assert property (
    syncControl_reg[7] |=> syncCtl.field60 == $past(detected60))
    else $error("field rate does not follow detector");
  AST_FIELD_FORCED: assert property (
    !syncControl_reg[7] |=> syncCtl.field60 == $past(syncControl_reg[6]))
    else $error("field rate does not follow selection");
  AST_ODD_EVEN: assert property (
    fieldStart && (sourceInterlaced || syncControl_reg[5]) |=>
    oddEven != $past(oddEven))
    else $error("odd/even missed a toggle");
  AST_ODD_HOLD: assert property (
    !(fieldStart && (sourceInterlaced || syncControl_reg[5])) |=>
    $stable(oddEven))
    else $error("odd/even toggled without cause");
  AST_HTC_VTR: assert property (
    wrEn && subAddr == 8'h08 && wrData[4:3] == 2'h1 ##1 !wrEn |=>
    syncCtl.hmodeVtr && !syncCtl.hmodeFast)
    else $error("time constant decode wrong");
  AST_LOOP_OPEN: assert property (
    ##1 syncCtl.horizLoopOpen == $past(syncControl_reg[2]))
    else $error("loop open does not track register");
  AST_VNR_BYPASS: assert property (
    vnr == 2'h3 |=> syncCtl.vnrBypass && !syncCtl.vnrNormal)
    else $error("noise bypass decode wrong");
  AST_BYPASS: assert property (
    luminanceControl_reg[7] |=> !lumaCtl.trapOn && !lumaCtl.combOn)
    else $error("bypass left a filter on");
  AST_COMB: assert property (
    luminanceControl_reg[7:6] == 2'h1 |=> lumaCtl.combOn && !lumaCtl.trapOn)
    else $error("comb select not honoured");
  AST_DELAY: assert property (
    combPath |=> lumaCtl.extraLines == 2'h0)
    else $error("extra delay in comb mode");
  AST_NOTCH: assert property (
    ##1 lumaCtl.notchWide == $past(luminanceControl_reg[4]))
    else $error("notch width wrong");
  AST_SHARP: assert property (
    sharp == 4'h1 |=> lumaCtl.peakOn && lumaCtl.peakStrength == 3'h7)
    else $error("strongest peaking decode wrong");
  AST_BRIGHT: assert property (
    lumaBrightnessOffset_reg == 8'h80 && $stable(lumaBrightnessOffset_reg)
    |=> lumaOut == $past(lumaIn))
    else $error("nominal brightness altered luma");
  AST_HTC_TV: assert property (
    htc == vsl_pkg::HTC_TV |=>
    syncCtl.hmodeTv && !syncCtl.hmodeVtr && !syncCtl.hmodeFast)
    else $error("tv time constant decode wrong");
  AST_HTC_FAST: assert property (
    htc == vsl_pkg::HTC_FAST |=>
    syncCtl.hmodeFast && !syncCtl.hmodeTv && !syncCtl.hmodeVtr)
    else $error("fast time constant decode wrong");
  AST_VNR_NORMAL: assert property (
    vnr == 2'h0 |=> syncCtl.vnrNormal && !syncCtl.vnrFast &&
    !syncCtl.vnrFreeRun && !syncCtl.vnrBypass)
    else $error("normal noise decode wrong");
  AST_VNR_FAST: assert property (
    vnr == 2'h1 |=> syncCtl.vnrFast && !syncCtl.vnrNormal)
    else $error("fast noise decode wrong");
  AST_VNR_FREE: assert property (
    vnr == 2'h2 |=> syncCtl.vnrFreeRun && !syncCtl.vnrBypass)
    else $error("free running noise decode wrong");
  AST_TRAP: assert property (
    luminanceControl_reg[7:6] == 2'h0 |=> lumaCtl.trapOn && !lumaCtl.combOn)
    else $error("trap not selected");
  AST_DELAY_LINES: assert property (
    luminanceControl_reg[5] && !combPath && syncCtl.field60 |=>
    lumaCtl.extraLines == vsl_pkg::DELAY_LINES_NTSC)
    else $error("one line delay missing at 60 Hz");
  AST_FLAT: assert property (
    sharp == 4'h0 |=> lumaCtl.sharpFlat && !lumaCtl.peakOn &&
    !lumaCtl.lowpassOn)
    else $error("flat response decode wrong");
  AST_LOWPASS: assert property (
    sharp[3] |=> lumaCtl.lowpassOn && !lumaCtl.peakOn &&
    lumaCtl.lowpassStrength == $past(sharp[2:0]))
    else $error("low-pass decode wrong");
  AST_BRIGHT_TOP: assert property (
    lumaBrightnessOffset_reg == 8'hFF && lumaIn >= 8'h80 |=> lumaOut == 8'hFF)
    else $error("brightest offset did not clip");

  COV_FORCED_TOGGLE: cover property (fieldStart && !sourceInterlaced &&
    syncControl_reg[5]);
  COV_COMB: cover property (lumaCtl.combOn);
  COV_LOWPASS: cover property (lumaCtl.lowpassOn);
  COV_READ: cover property (rdEn ##1 rdData != 8'h00);
endmodule // vsl_regs

// File: test/vsl_host_model.sv
// host model that programs the sync and luma register bank
// assumes tasks are called just after a rising edge of clk
`timescale 1ns/1ps
module vsl_host_model (
  // clock
  input wire logic clk,
  // subaddress port
  output logic wrEn,
  output logic rdEn,
  output logic [7:0] subAddr,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData
);
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    subAddr = 8'h00;
    wrData = 8'h00;
  end
  // ==========================================================
  // byte transfers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    subAddr = a;
    wrData = d;
    wrEn = 1'b1;
    @(posedge clk);
    #1;
    wrEn = 1'b0;
    // released data inverted, never a stale hold
    wrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    #1;
    subAddr = a;
    rdEn = 1'b1;
    @(posedge clk);
    #1;
    rdEn = 1'b0;
    q = rdData;
  endtask
endmodule // vsl_host_model

// File: test/video_sync_luma_control_regs_tb.sv
// testbench of the sync and luma register bank
// assumes vsl_regs, vsl_pkg and the host model are compiled first
`timescale 1ns/1ps
module video_sync_luma_control_regs_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic det = 1'b0;
  logic si = 1'b0;
  logic fs = 1'b0;
  logic wrEn, rdEn, oddEven, e;
  logic [7:0] subAddr, wrData, rdData, lumaOut, rv;
  logic [7:0] lumaIn = 8'h00;
  vsl_pkg::vsl_sync_ctl_s sc;
  vsl_pkg::vsl_luma_ctl_s lc;
  int failures = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  vsl_regs dut (.clk(clk), .reset_n(reset_n), .wrEn(wrEn), .rdEn(rdEn),
    .subAddr(subAddr), .wrData(wrData), .rdData(rdData), .detected60(det),
    .sourceInterlaced(si), .fieldStart(fs), .lumaIn(lumaIn),
    .syncCtl(sc), .lumaCtl(lc), .oddEven(oddEven), .lumaOut(lumaOut));
  vsl_host_model host (.clk(clk), .wrEn(wrEn), .rdEn(rdEn),
    .subAddr(subAddr), .wrData(wrData), .rdData(rdData));
  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wset(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic fld(input logic ilace, input logic [7:0] exp);
    si = ilace;
    e = oddEven;
    fs = 1'b1;
    @(posedge clk);
    #1 fs = 1'b0;
    @(posedge clk);
    #1;
    chk({7'h00, oddEven ^ e}, exp);
  endtask
  task automatic bri(input logic [7:0] b, y, exp);
    wset(8'h0A, b);
    lumaIn = y;
    @(posedge clk);
    #1;
    chk(lumaOut, exp);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    host.rd(8'h08, rv);
    chk(rv, vsl_pkg::SYNC_CONTROL_RESET);
    host.rd(8'h09, rv);
    chk(rv, vsl_pkg::LUMINANCE_CONTROL_RESET);
    host.rd(8'h0A, rv);
    chk(rv, vsl_pkg::LUMA_BRIGHTNESS_OFFSET_RESET);
    host.wr(8'h0B, 8'h55);
    host.rd(8'h0B, rv);
    chk(rv, vsl_pkg::UNMAPPED_READ);
    host.rd(8'h0A, rv);
    chk(rv, vsl_pkg::LUMA_BRIGHTNESS_OFFSET_RESET);
    host.wr(8'h09, 8'hA5);
    host.rd(8'h09, rv);
    chk(rv, 8'hA5);
    $display("test regs done");
  endtask
  task automatic t_sync;
    for (int i = 0; i < 4; i++) begin
      // each noise code in turn, with auto off
      wset(8'h08, {1'b0, i[0], 1'b0, i[1:0], i[0], i[1:0]});
      chk({7'h00, sc.field60}, {7'h00, i[0]});
      chk({sc.hmodeTv, sc.hmodeVtr, sc.hmodeFast}, {i==0, i==1, i[1]});
      chk({7'h00, sc.horizLoopOpen}, {7'h00, i[0]});
      chk({4'h0, sc[3:0]}, 8'h08 >> i);
    end
    det = 1'b1;
    wset(8'h08, 8'h98);
    chk({7'h00, sc.field60}, 8'h01);
    det = 1'b0;
    wset(8'h08, 8'hD8);
    chk({7'h00, sc.field60}, 8'h00);
    $display("test sync done");
  endtask
  task automatic t_field;
    fld(1'b0, 8'h00);
    fld(1'b1, 8'h01);
    wset(8'h08, 8'hB8);
    fld(1'b0, 8'h01);
    $display("test field done");
  endtask
  task automatic t_luma;
    wset(8'h09, 8'h80);
    chk({lc.trapOn, lc.combOn}, 8'h00);
    wset(8'h09, 8'h40);
    chk({lc.trapOn, lc.combOn}, 8'h01);
    wset(8'h09, 8'h20);
    chk({lc.trapOn, lc.extraLines}, 8'h06);
    wset(8'h08, 8'h58);
    chk({6'h00, lc.extraLines}, 8'h01);
    wset(8'h09, 8'h10);
    chk({lc.notchWide, lc.sharpFlat, lc.peakOn, lc.lowpassOn}, 8'h0C);
    wset(8'h09, 8'h01);
    chk({lc.sharpFlat, lc.peakOn, lc.peakStrength}, 8'h0F);
    wset(8'h09, 8'h07);
    chk({lc.notchWide, lc.peakOn, lc.peakStrength}, 8'h09);
    wset(8'h09, 8'h08);
    chk({lc.peakOn, lc.lowpassOn, lc.lowpassStrength}, 8'h08);
    wset(8'h09, 8'h0F);
    chk({lc.lowpassOn, lc.lowpassStrength}, 8'h0F);
    $display("test luma done");
  endtask
  task automatic t_bright;
    bri(8'h80, 8'h40, 8'h40);
    bri(8'hFF, 8'hF0, 8'hFF);
    bri(8'h00, 8'h10, 8'h00);
    bri(8'h90, 8'h20, 8'h30);
    $display("test bright done");
  endtask
  // ==========================================================
  // run control
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    t_regs();
    t_sync();
    t_field();
    t_luma();
    t_bright();
    give_verdict();
  end
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
endmodule // video_sync_luma_control_regs_tb
